// ==== core/scr_router.sv ====
// serial to packet-network frame router with its register slave
`timescale 1ns/1ns
`include "scr_defs.svh"
module scr_router #(
	parameter int unsigned SEC_CYCLES = `SCR_SEC_CYCLES,
	parameter int unsigned RSP_CYCLES = `SCR_RSP_CYCLES
) (
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic             HREADYOUT,
	output logic             HRESP,
	output logic [31:0]      HRDATA,
	input  wire logic [7:0]  SER_RX_DATA,
	input  wire logic        SER_RX_VALID,
	output logic             SER_RX_READY,
	output logic [7:0]       SER_TX_DATA,
	output logic             SER_TX_VALID,
	input  wire logic        SER_TX_READY,
	input  wire logic [7:0]  NET_RX_DATA,
	input  wire logic        NET_RX_VALID,
	input  wire logic        NET_RX_LAST,
	input  wire logic [2:0]  NET_RX_SRC,
	output logic             NET_RX_READY,
	output logic [7:0]       NET_TX_DATA,
	output logic [7:0]       NET_TX_DEST,
	output logic             NET_TX_EOF,
	output logic             NET_TX_VALID,
	input  wire logic        NET_TX_READY,
	output logic [7:0]       LOC_DATA,
	output logic             LOC_LAST,
	output logic             LOC_EOF,
	output logic             LOC_FROM_NET,
	output logic [2:0]       LOC_SRC,
	output logic             LOC_VALID,
	input  wire logic        LOC_READY,
	input  wire logic        SIM_PIN_REJECT,
	output logic             LOGIN_ENABLE,
	output logic             DEV_RESET
);
	import scr_pkg::*;

	scr_mode_t   mode;
	logic        use_pkt;
	logic [7:0]  bus_id;
	logic [15:0] resv_time;
	logic [15:0] gap_len;
	logic [7:0]  auth_en;
	logic [31:0] auth_ip  [`SCR_NSLOT];
	logic [31:0] route_ip [`SCR_NSLOT];
	logic [7:0]  route_id [`SCR_NSLOT];
	logic        ph_wr;
	logic [7:0]  ph_addr;
	logic        wr_en;
	logic        cfg_wr;
	logic        unlock;
	logic [31:0] rd_val;
	logic        srst;
	logic        ovf;
	logic [1:0]  pin_fail;
	logic        transp;
	logic [63:0] ip_hit;
	logic [63:0] rid_flat;
	logic        in_frame;
	logic [15:0] quiet;
	logic        gap_hit;
	logic [7:0]  fr_dest;
	logic        fr_loc;
	logic [7:0]  first_dest;
	logic        first_loc;
	scr_word_t   word_in;
	scr_word_t   wo;
	logic        push_v;
	logic        fifo_rdy;
	logic        fifo_ov;
	logic        pop;
	logic        wo_net;
	logic        net_send;
	logic        fifo_loc;
	logic        fifo_loc_go;
	scr_net_t    net_st;
	scr_own_t    owner;
	logic        to_loc;
	logic        net_block;
	logic        loc_free;
	logic        net_loc_go;
	logic        net_acc;
	logic [2:0]  orig_src;
	logic        wait_rsp;
	logic [23:0] rsp_cnt;
	logic        fwd_done;
	logic        resv_act;
	logic [2:0]  resv_slot;
	logic [15:0] resv_left;
	logic [23:0] resv_pre;
	logic        resv_hit;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// offsets that answer on the bus
	function automatic logic addr_mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && ((a <= `SCR_OFS_LAST) ||
		       ((a >= `SCR_OFS_BANKLO) && (a <= `SCR_OFS_BANKHI)));
	endfunction

	// routing entries chosen by a frame address
	function automatic logic [7:0] id_sel(input logic [7:0]  addr,
	                                      input logic [63:0] rid,
	                                      input logic        bcast);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < `SCR_NSLOT; i++) begin
			s[i] = (rid[i*8 +: 8] == addr) || (rid[i*8 +: 8] == 8'h00) ||
			       (bcast && (addr == 8'h00));
		end
		return s;
	endfunction

	// entries to authorized slots: one bit per authorized slot
	function automatic logic [7:0] sel_dest(input logic [7:0]  sel,
	                                        input logic [63:0] hit,
	                                        input logic [7:0]  en);
		logic [7:0] d;
		d = 8'h00;
		for (int j = 0; j < `SCR_NSLOT; j++) begin
			d[j] = en[j] && |(sel & hit[j*8 +: 8]);
		end
		return d;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// bus slave: zero wait states, always OKAY

	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;
	assign wr_en     = ph_wr && addr_mapped(ph_addr);
	assign cfg_wr    = wr_en && (ph_addr != `SCR_OFS_STATUS);
	assign unlock    = wr_en && (ph_addr == `SCR_OFS_CTRL) &&
	                   HWDATA[`SCR_CTRL_UNLOCK];

	// address phase capture; upper address bits must be zero
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ph_wr   <= 1'b0;
			ph_addr <= 8'h00;
		end else begin
			ph_wr   <= HSEL && HTRANS[1] && HREADY && HWRITE &&
			           (HADDR[31:8] == 24'h000000);
			ph_addr <= HADDR[7:0];
		end
	end

	// read data is sampled in the address phase, so it is one cycle old
	always_comb begin
		rd_val = 32'h00000000;
		if (addr_mapped(HADDR[7:0]) && (HADDR[31:8] == 24'h000000)) begin
			unique case (HADDR[7:5])
			`SCR_BANK_AUTHIP:  rd_val = auth_ip[HADDR[4:2]];
			`SCR_BANK_ROUTEIP: rd_val = route_ip[HADDR[4:2]];
			`SCR_BANK_ROUTEID: rd_val = {24'h000000, route_id[HADDR[4:2]]};
			default: begin
				unique case (HADDR[7:0])
				`SCR_OFS_CTRL:   rd_val = {29'h0, use_pkt, mode};
				`SCR_OFS_BUSID:  rd_val = {24'h0, bus_id};
				`SCR_OFS_RESV:   rd_val = {16'h0, resv_time};
				`SCR_OFS_GAP:    rd_val = {16'h0, gap_len};
				`SCR_OFS_AUTHEN: rd_val = {24'h0, auth_en};
				default: rd_val = {22'h0, pin_fail, fifo_ov,
				                   (pin_fail == `SCR_PIN_LIMIT), wait_rsp,
				                   resv_slot, resv_act, ovf};
				endcase
			end
			endcase
		end
	end

	// read data register
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			HRDATA <= 32'h00000000;
		end else if (HSEL && HTRANS[1] && HREADY && !HWRITE) begin
			HRDATA <= rd_val;
		end
	end

	// configuration registers survive the datapath reset they trigger
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			mode      <= scr_mode_t'(`SCR_RST_MODE);
			use_pkt   <= `SCR_RST_PKT;
			bus_id    <= `SCR_RST_BUSID;
			resv_time <= `SCR_RST_RESV;
			gap_len   <= `SCR_RST_GAP;
			auth_en   <= `SCR_RST_AUTHEN;
			for (int i = 0; i < `SCR_NSLOT; i++) begin
				auth_ip[i]  <= 32'h00000000;
				route_ip[i] <= 32'h00000000;
				route_id[i] <= 8'h00;
			end
		end else if (cfg_wr) begin
			unique case (ph_addr[7:5])
			`SCR_BANK_AUTHIP:  auth_ip[ph_addr[4:2]]  <= HWDATA;
			`SCR_BANK_ROUTEIP: route_ip[ph_addr[4:2]] <= HWDATA;
			`SCR_BANK_ROUTEID: route_id[ph_addr[4:2]] <= HWDATA[7:0];
			default: begin
				if (ph_addr == `SCR_OFS_CTRL) begin
					mode    <= scr_mode_t'(HWDATA[1:0]);
					use_pkt <= HWDATA[`SCR_CTRL_PKT];
				end
				if (ph_addr == `SCR_OFS_BUSID) bus_id <= HWDATA[7:0];
				if (ph_addr == `SCR_OFS_RESV) resv_time <= HWDATA[15:0];
				if (ph_addr == `SCR_OFS_GAP) gap_len <= HWDATA[15:0];
				if (ph_addr == `SCR_OFS_AUTHEN) auth_en <= HWDATA[7:0];
			end
			endcase
		end
	end

	// a configuration write pulses the device reset
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			DEV_RESET <= 1'b1;
		end else begin
			DEV_RESET <= cfg_wr;
		end
	end
	assign srst = RST || DEV_RESET;

	// pin rejects: a reject in the unlock cycle still counts
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			pin_fail <= 2'h0;
		end else if (SIM_PIN_REJECT && (pin_fail != `SCR_PIN_LIMIT)) begin
			pin_fail <= pin_fail + 2'h1;
		end else if (unlock && !SIM_PIN_REJECT) begin
			pin_fail <= 2'h0;
		end
	end
	assign LOGIN_ENABLE = (pin_fail != `SCR_PIN_LIMIT);

	// overflow flag: a new drop wins over the clear
	always_ff @(posedge REF_CLK) begin
		if (srst) begin
			ovf <= 1'b0;
		end else begin
			ovf <= (push_v && !fifo_rdy) || (ovf && !(wr_en &&
			       (ph_addr == `SCR_OFS_STATUS) && HWDATA[`SCR_ST_OVF]));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// routing decision for serial frames

	assign transp = (mode != MODE_MASTER) && (mode != MODE_SLAVE);

	// address match table between routing entries and authorized slots
	always_comb begin
		ip_hit   = 64'h0;
		rid_flat = 64'h0;
		for (int i = 0; i < `SCR_NSLOT; i++) begin
			rid_flat[i*8 +: 8] = route_id[i];
			for (int j = 0; j < `SCR_NSLOT; j++) begin
				ip_hit[j*8 + i] = (route_ip[i] == auth_ip[j]);
			end
		end
	end

	// destinations fixed by the first byte, the frame address
	always_comb begin
		first_loc  = 1'b0;
		first_dest = 8'h00;
		unique case (mode)
		MODE_MASTER: begin
			if (SER_RX_DATA == bus_id) begin
				first_loc = 1'b1;
			end else begin
				first_dest = sel_dest(id_sel(SER_RX_DATA, rid_flat, 1'b1),
				                      ip_hit, auth_en);
			end
		end
		MODE_SLAVE: begin
			first_dest = sel_dest(id_sel(SER_RX_DATA, rid_flat, 1'b0),
			                      ip_hit, auth_en) |
			             (wait_rsp ? (8'h01 << orig_src) : 8'h00);
		end
		default: begin
			// code 2'b11 is illegal and falls back to transparent
			first_dest = resv_act ? (8'h01 << resv_slot) : auth_en;
		end
		endcase
	end

	// silence after the last byte closes the frame
	assign gap_hit = in_frame && !SER_RX_VALID && (quiet >= gap_len);

	always_ff @(posedge REF_CLK) begin
		if (srst) begin
			in_frame <= 1'b0;
			quiet    <= 16'h0000;
			fr_dest  <= 8'h00;
			fr_loc   <= 1'b0;
		end else if (SER_RX_VALID) begin
			if (!in_frame) begin
				fr_dest <= first_dest;
				fr_loc  <= first_loc;
			end
			in_frame <= 1'b1;
			quiet    <= 16'h0000;
		end else if (gap_hit) begin
			in_frame <= 1'b0;
		end else if (in_frame && (quiet != 16'hFFFF)) begin
			quiet <= quiet + 16'h0001;
		end
	end

	// beats and end markers share the buffer; a full buffer drops them
	assign push_v       = SER_RX_VALID || gap_hit;
	assign word_in.eof  = gap_hit;
	assign word_in.loc  = in_frame ? fr_loc : first_loc;
	assign word_in.dest = in_frame ? fr_dest : first_dest;
	assign word_in.data = SER_RX_VALID ? SER_RX_DATA : 8'h00;
	assign SER_RX_READY = fifo_rdy;

	scr_fifo #(
		.WIDTH ($bits(scr_word_t)),
		.DEPTH (`SCR_FIFO_DEPTH)
	) u_fifo (
		.clk       (REF_CLK),
		.rst       (srst),
		.in_data   (word_in),
		.in_valid  (push_v),
		.in_ready  (fifo_rdy),
		.out_data  (wo),
		.out_valid (fifo_ov),
		.out_ready (pop)
	);

	////////////////////////////////////////////////////////////////////////
	// buffer drain to network or local port

	assign wo_net      = fifo_ov && !wo.loc;
	assign net_send    = wo_net && use_pkt && (wo.dest != 8'h00);
	assign fifo_loc    = fifo_ov && wo.loc;
	assign fifo_loc_go = fifo_loc && (owner != OWN_NET);
	// unroutable or message-only frames are discarded without stalling
	assign pop = net_send ? NET_TX_READY :
	             wo_net ? 1'b1 : (fifo_loc_go && LOC_READY);

	assign NET_TX_VALID = net_send;
	assign NET_TX_DATA  = wo.data;
	assign NET_TX_DEST  = wo.dest;
	assign NET_TX_EOF   = wo.eof;

	////////////////////////////////////////////////////////////////////////
	// network frames to serial port or local port

	always_comb begin
		unique case (net_st)
		NET_IDLE:   to_loc = !transp && (NET_RX_DATA == bus_id);
		NET_TO_LOC: to_loc = 1'b1;
		NET_TO_SER: to_loc = 1'b0;
		default:    to_loc = 1'b0;
		endcase
	end

	// no new network frame is taken while a slave reply is awaited
	assign net_block  = (net_st == NET_IDLE) && wait_rsp;
	assign loc_free   = (owner == OWN_NET) || ((owner == OWN_NONE) && !fifo_loc);
	assign net_loc_go = NET_RX_VALID && !net_block && to_loc && loc_free;
	assign NET_RX_READY = !net_block &&
	                      (to_loc ? (loc_free && LOC_READY) : SER_TX_READY);
	assign net_acc      = NET_RX_VALID && NET_RX_READY;
	assign SER_TX_VALID = NET_RX_VALID && !net_block && !to_loc;
	assign SER_TX_DATA  = NET_RX_DATA;

	assign LOC_VALID    = fifo_loc_go || net_loc_go;
	assign LOC_DATA     = net_loc_go ? NET_RX_DATA : wo.data;
	assign LOC_LAST     = net_loc_go && NET_RX_LAST;
	assign LOC_EOF      = fifo_loc_go && wo.eof;
	assign LOC_FROM_NET = net_loc_go;
	assign LOC_SRC      = net_loc_go ? NET_RX_SRC : 3'h0;

	// network frame progress and sender capture
	always_ff @(posedge REF_CLK) begin
		if (srst) begin
			net_st   <= NET_IDLE;
			orig_src <= 3'h0;
		end else if (net_acc) begin
			if (net_st == NET_IDLE) orig_src <= NET_RX_SRC;
			if (NET_RX_LAST) begin
				net_st <= NET_IDLE;
			end else if (net_st == NET_IDLE) begin
				net_st <= to_loc ? NET_TO_LOC : NET_TO_SER;
			end
		end
	end

	// local port is held by one source for a whole frame
	always_ff @(posedge REF_CLK) begin
		if (srst) begin
			owner <= OWN_NONE;
		end else if (fifo_loc_go && LOC_READY) begin
			owner <= wo.eof ? OWN_NONE : OWN_FIFO;
		end else if (net_loc_go && LOC_READY) begin
			owner <= NET_RX_LAST ? OWN_NONE : OWN_NET;
		end
	end

	// slave mode reply wait, ended by a serial frame end or timeout
	assign fwd_done = net_acc && NET_RX_LAST && !to_loc && (mode == MODE_SLAVE);
	always_ff @(posedge REF_CLK) begin
		if (srst) begin
			wait_rsp <= 1'b0;
			rsp_cnt  <= 24'h000000;
		end else if (fwd_done) begin
			wait_rsp <= 1'b1;
			rsp_cnt  <= 24'h000000;
		end else if (wait_rsp &&
		             (gap_hit || (rsp_cnt == 24'(RSP_CYCLES - 1)))) begin
			wait_rsp <= 1'b0;
		end else if (wait_rsp) begin
			rsp_cnt <= rsp_cnt + 24'h000001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// channel reservation in transparent mode

	// only packets received from the reserved unit restart the time
	assign resv_hit = net_acc && (net_st == NET_IDLE) && transp &&
	                  (resv_time != 16'h0000) &&
	                  (!resv_act || (NET_RX_SRC == resv_slot));

	always_ff @(posedge REF_CLK) begin
		if (srst) begin
			resv_act  <= 1'b0;
			resv_slot <= 3'h0;
			resv_left <= 16'h0000;
			resv_pre  <= 24'h000000;
		end else if (resv_hit) begin
			resv_act  <= 1'b1;
			resv_slot <= NET_RX_SRC;
			resv_left <= resv_time;
			resv_pre  <= 24'h000000;
		end else if (resv_act) begin
			if (resv_pre == 24'(SEC_CYCLES - 1)) begin
				resv_pre <= 24'h000000;
				if (resv_left <= 16'h0001) resv_act <= 1'b0;
				resv_left <= resv_left - 16'h0001;
			end else begin
				resv_pre <= resv_pre + 24'h000001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	chk_bcast_all: assert property (@(posedge REF_CLK) disable iff (srst)
		(SER_RX_VALID && !in_frame && transp && !resv_act)
		|=> (fr_dest == $past(auth_en)))
		else $error("transparent frame not sent to all authorized");

	chk_resv_single: assert property (@(posedge REF_CLK) disable iff (srst)
		(SER_RX_VALID && !in_frame && transp && resv_act)
		|=> (fr_dest == (8'h01 << $past(resv_slot))))
		else $error("reserved frame not sent to reserved unit only");

	chk_resv_reload: assert property (@(posedge REF_CLK) disable iff (srst)
		(resv_act && net_acc && (net_st == NET_IDLE) &&
		 (NET_RX_SRC != resv_slot))
		|=> $stable(resv_slot) && !(resv_left > $past(resv_left)))
		else $error("reservation moved by another unit");

	chk_resv_zero: assert property (@(posedge REF_CLK) disable iff (srst)
		($past(resv_time) == 16'h0000 && resv_time == 16'h0000 && !resv_act)
		|=> !resv_act)
		else $error("reservation taken with zero time");

	chk_own_local: assert property (@(posedge REF_CLK) disable iff (srst)
		(SER_RX_VALID && !in_frame && (mode == MODE_MASTER) &&
		 (SER_RX_DATA == bus_id)) |=> fr_loc && (fr_dest == 8'h00))
		else $error("own address frame not kept local");

	chk_master_pass: assert property (@(posedge REF_CLK) disable iff (srst)
		(NET_RX_VALID && (net_st == NET_IDLE) && (mode == MODE_MASTER) &&
		 (NET_RX_DATA != bus_id)) |-> SER_TX_VALID && !LOC_FROM_NET)
		else $error("foreign network frame not passed to serial");

	chk_wait_block: assert property (@(posedge REF_CLK) disable iff (srst)
		fwd_done |=> wait_rsp && !NET_RX_READY)
		else $error("next network frame taken during reply wait");

	chk_wait_bound: assert property (@(posedge REF_CLK) disable iff (srst)
		wait_rsp |-> (rsp_cnt < 24'(RSP_CYCLES)))
		else $error("reply wait exceeded its timeout");

	chk_pkt_off: assert property (@(posedge REF_CLK) disable iff (srst)
		!use_pkt |-> !NET_TX_VALID)
		else $error("packet sent in message-only operation");

	chk_pin_block: assert property (@(posedge REF_CLK) disable iff (RST)
		(!LOGIN_ENABLE && !unlock) |=> !LOGIN_ENABLE)
		else $error("login unblocked without unlock");

	chk_cfg_reset: assert property (@(posedge REF_CLK) disable iff (RST)
		cfg_wr |=> DEV_RESET ##1 (!in_frame && !wait_rsp && !resv_act))
		else $error("configuration write did not reset datapath");
endmodule

// ==== core/scr_defs.svh ====
// offsets, field positions, reset values and timing counts of the router
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

// clock and timing
`define SCR_CLK_HZ         10000000
`define SCR_CYC_PER_MS     (`SCR_CLK_HZ / 1000)
`define SCR_SEC_MS         1000
`define SCR_RSP_TIMEOUT_MS 500
`define SCR_SEC_CYCLES     (`SCR_CYC_PER_MS * `SCR_SEC_MS)
`define SCR_RSP_CYCLES     (`SCR_CYC_PER_MS * `SCR_RSP_TIMEOUT_MS)

// register byte offsets
`define SCR_OFS_CTRL    8'h00
`define SCR_OFS_BUSID   8'h04
`define SCR_OFS_RESV    8'h08
`define SCR_OFS_GAP     8'h0C
`define SCR_OFS_AUTHEN  8'h10
`define SCR_OFS_STATUS  8'h14
`define SCR_OFS_LAST    8'h14
`define SCR_OFS_BANKLO  8'h20
`define SCR_OFS_BANKHI  8'h7C
// banks of eight words, selected by address bits 7:5
`define SCR_BANK_AUTHIP  3'h1
`define SCR_BANK_ROUTEIP 3'h2
`define SCR_BANK_ROUTEID 3'h3

// field positions
`define SCR_CTRL_PKT    2
`define SCR_CTRL_UNLOCK 3
`define SCR_ST_OVF      0

// reset values
`define SCR_RST_MODE    2'h0
`define SCR_RST_PKT     1'h1
`define SCR_RST_BUSID   8'h01
`define SCR_RST_RESV    16'h0000
`define SCR_RST_GAP     16'h9C40
`define SCR_RST_AUTHEN  8'h00

// sizes and limits
`define SCR_NSLOT       8
`define SCR_FIFO_DEPTH  8
`define SCR_PIN_LIMIT   2'h2

`endif

// ==== core/scr_pkg.sv ====
// types shared by the router and its frame buffer
package scr_pkg;

	// operating mode held in the control register
	typedef enum logic [1:0] {
		MODE_TRANSP = 2'b00,
		MODE_MASTER = 2'b01,
		MODE_SLAVE  = 2'b10
	} scr_mode_t;

	// where the current network frame is being delivered
	typedef enum logic [1:0] {
		NET_IDLE   = 2'b00,
		NET_TO_SER = 2'b01,
		NET_TO_LOC = 2'b10
	} scr_net_t;

	// which source holds the local execution port
	typedef enum logic [1:0] {
		OWN_NONE = 2'b00,
		OWN_FIFO = 2'b01,
		OWN_NET  = 2'b10
	} scr_own_t;

	// one buffered serial beat with its frame routing
	typedef struct packed {
		logic       eof;
		logic       loc;
		logic [7:0] dest;
		logic [7:0] data;
	} scr_word_t;

endpackage

// ==== core/scr_fifo.sv ====
// synchronous first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ns
module scr_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             full;
	logic             empty;

	// extra pointer bit tells full from empty
	assign full      = (wr_ptr[AW] != rd_ptr[AW]) &&
	                   (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign empty     = (wr_ptr == rd_ptr);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rd_ptr[AW-1:0]];

	// storage is not reset; only the pointers matter
	always_ff @(posedge clk) begin
		if (in_valid && !full) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	// write pointer
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr <= '0;
		end else if (in_valid && !full) begin
			wr_ptr <= wr_ptr + 1'b1;
		end
	end

	// read pointer
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_ptr <= '0;
		end else if (out_ready && !empty) begin
			rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

// ==== tb/scr_dev.sv ====
// field serial device model: sends frames, takes reply bytes slowly
`timescale 1ns/1ns
module scr_dev (
	input  wire logic       clk,
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	logic [7:0] got[$];
	initial {rx_data, rx_valid, tx_ready} = '0;
	// bytes two cycles apart, then silence past the gap closes the frame
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) begin
			@(posedge clk);
			rx_data <= b[i];
			rx_valid <= 1'b1;
			@(posedge clk);
			rx_data <= ~b[i]; // a released line must not hold its value
			rx_valid <= 1'b0;
		end
		repeat (12) @(posedge clk);
	endtask
	// ready every other cycle, so the router meets a stalling receiver
	always @(posedge clk) begin
		tx_ready <= ~tx_ready;
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
	end
endmodule

// ==== tb/serial_to_cellular_frame_router_tb.sv ====
// self-checking bench for the serial to network frame router
`timescale 1ns/1ns
`include "scr_defs.svh"
module serial_to_cellular_frame_router_tb;
	logic clk, rst, hw, nrdy, lrdy, pin, stall, hro, sv, sr, tv, tr;
	logic nv, ne, nrr, lv, le, login, dres, llast, lf, hrs;
	logic [2:0] lsrc, ns = 3'h1;
	logic [1:0] ht;
	logic [7:0] ha, sd, td, nd, ndst, ld, fq[$];
	logic [31:0] hwd, hrd, r;
	logic [31:0] rs = 32'h26;
	logic [12:0] nrx;
	logic [16:0] seen[$];
	int n_errors, cmp_count;
	logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
	logic [31:0] rv[6] = '{32'h4, 32'h1, 32'h0, 32'h9C40, 32'h0, 32'h0};
	logic [7:0] wa[14] = '{8'h20, 8'h24, 8'h40, 8'h44, 8'h48, 8'h60,
		8'h64, 8'h68, 8'h6C, 8'h70, 8'h74, 8'h78, 8'h7C, 8'h10};
	logic [31:0] wd[14] = '{32'hA01, 32'hA02, 32'hA01, 32'hA02, 32'hA01,
		32'h5, 32'h7, 32'h0, 32'hFF, 32'hFF, 32'hFF, 32'hFF, 32'hFF, 32'h3};
	logic [7:0] fa[5] = '{8'h00, 8'h05, 8'h07, 8'h09, 8'h01};
	scr_router #(.SEC_CYCLES(20), .RSP_CYCLES(50)) i_scr_router (
		.REF_CLK(clk), .RST(rst), .HSEL(1'b1), .HADDR({24'h0, ha}),
		.HTRANS(ht), .HWRITE(hw), .HSIZE(3'h2), .HWDATA(hwd),
		.HREADY(hro), .HREADYOUT(hro), .HRESP(hrs), .HRDATA(hrd),
		.SER_RX_DATA(sd), .SER_RX_VALID(sv), .SER_RX_READY(sr),
		.SER_TX_DATA(td), .SER_TX_VALID(tv), .SER_TX_READY(tr),
		.NET_RX_DATA(nrx[7:0]), .NET_RX_VALID(nrx[12]),
		.NET_RX_LAST(nrx[11]), .NET_RX_SRC(nrx[10:8]),
		.NET_RX_READY(nrr), .NET_TX_DATA(nd), .NET_TX_DEST(ndst),
		.NET_TX_EOF(ne), .NET_TX_VALID(nv), .NET_TX_READY(nrdy),
		.LOC_DATA(ld), .LOC_LAST(llast), .LOC_EOF(le), .LOC_FROM_NET(lf),
		.LOC_SRC(lsrc), .LOC_VALID(lv), .LOC_READY(lrdy),
		.SIM_PIN_REJECT(pin), .LOGIN_ENABLE(login), .DEV_RESET(dres));
	scr_dev i_scr_dev (.clk(clk), .rx_data(sd), .rx_valid(sv),
		.tx_data(td), .tx_valid(tv), .tx_ready(tr));
	// free-running reference clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	function automatic logic [7:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs[7:0];
	endfunction
	// expected destination slots of a serial frame; zero means local
	function automatic logic [7:0] dst(input logic [7:0] a);
		if (a == 8'h01)
			return 8'h00;
		return (a == 8'h00 || a == 8'h07) ? 8'h03 : 8'h01;
	endfunction
	// random stalls on both outputs, and capture of each accepted beat
	always @(posedge clk) begin
		if (nv && nrdy)
			seen.push_back({ne, ndst, nd});
		if (lv && lrdy)
			seen.push_back({le | llast, 4'h0, lf, lsrc, ld});
		nrdy <= !stall && rnd() > 8'h5F;
		lrdy <= rnd() > 8'h3F;
	end
	task automatic chk(input string n, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask
	// one single-word transfer; the answer lands in r
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		ht <= 2'h2;
		ha <= a;
		hw <= w;
		do @(posedge clk); while (hro !== 1'b1);
		ht <= 2'h0;
		hwd <= d;
		do @(posedge clk); while (hro !== 1'b1);
		r = hrd;
	endtask
	task automatic mk(input logic [7:0] a, input int n);
		fq = {a};
		repeat (n - 1) fq.push_back(rnd());
	endtask
	task automatic want(input logic [7:0] b[$], input logic [7:0] t,
		input bit eof);
		repeat (400) if (seen.size() < b.size() + eof) @(posedge clk);
		foreach (b[i]) chk("beat", seen[i], {1'b0, t, b[i]});
		if (eof) chk("end", seen[b.size()][16:8], {1'b1, t});
		seen.delete();
	endtask
	task automatic net_tx(input logic [7:0] b[$]);
		foreach (b[i]) begin
			nrx <= {1'b1, i == b.size() - 1, ns, b[i]};
			do @(posedge clk); while (nrr !== 1'b1);
		end
		nrx <= {5'h0, ~b[b.size() - 1]};
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (30000) @(posedge clk);
		n_errors++;
		conclude();
	end
	// main sequence
	initial begin
		{ht, hw, ha, hwd, pin, stall, nrx, nrdy, lrdy} = '0;
		rst = 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (ra[i]) begin
			bus(1'b0, ra[i], 32'h0);
			chk("reg", r, rv[i]);
		end
		bus(1'b1, `SCR_OFS_GAP, 32'h8);
		@(negedge clk) chk("devrst", dres, 32'h1);
		chk("resp", hrs, 32'h0);
		@(posedge clk);
		foreach (wa[i]) bus(1'b1, wa[i], wd[i]);
		$display("registers done");
		stall <= 1'b1;
		mk(rnd(), 9);
		i_scr_dev.send(fq);
		chk("rxrdy", sr, 32'h0);
		bus(1'b0, `SCR_OFS_STATUS, 32'h0);
		chk("ovf", r[0], 32'h1);
		stall <= 1'b0;
		want(fq[0:7], 8'h03, 1'b0);
		bus(1'b1, `SCR_OFS_CTRL, 32'h5);
		repeat (2) @(posedge clk);
		bus(1'b0, `SCR_OFS_STATUS, 32'h0);
		chk("clr", r[0], 32'h0);
		$display("transparent done");
		foreach (fa[i]) begin
			mk(fa[i], 3);
			i_scr_dev.send(fq);
			want(fq, dst(fa[i]), 1'b1);
		end
		mk(8'h33, 4);
		net_tx(fq);
		repeat (20) @(posedge clk);
		chk("ser", i_scr_dev.got.size(), 32'h4);
		foreach (fq[i]) chk("ser", i_scr_dev.got[i], fq[i]);
		// own-id network frame goes local, tagged with its sender slot
		mk(8'h01, 3);
		net_tx(fq);
		want(fq[0:1], 8'h09, 1'b1);
		$display("routing done");
		// slave side: forward, hold off the network, copy the reply
		bus(1'b1, `SCR_OFS_CTRL, 32'h6);
		repeat (2) @(posedge clk);
		mk(8'h09, 3);
		net_tx(fq);
		bus(1'b0, `SCR_OFS_STATUS, 32'h0);
		chk("wait", r[5], 32'h1);
		chk("fwd", i_scr_dev.got.size(), 32'h7);
		mk(8'h05, 3);
		i_scr_dev.send(fq);
		want(fq, 8'h03, 1'b1);
		mk(8'h05, 3);
		i_scr_dev.send(fq);
		want(fq, 8'h01, 1'b1);
		net_tx(fq);
		repeat (55) @(posedge clk);
		bus(1'b0, `SCR_OFS_STATUS, 32'h0);
		chk("tmo", r[5], 32'h0);
		$display("slave done");
		// reservation: slot 1 answers, slot 0 must not move it
		bus(1'b1, `SCR_OFS_RESV, 32'h1);
		bus(1'b1, `SCR_OFS_CTRL, 32'h4);
		repeat (2) @(posedge clk);
		net_tx(fq);
		ns = 3'h0;
		@(posedge clk);
		net_tx(fq);
		mk(rnd(), 3);
		i_scr_dev.send(fq);
		want(fq, 8'h02, 1'b1);
		mk(rnd(), 3);
		i_scr_dev.send(fq);
		want(fq, 8'h03, 1'b1);
		$display("reserve done");
		for (int i = 0; i < 2; i++) begin
			pin <= 1'b1;
			@(posedge clk);
			pin <= 1'b0;
			repeat (2) @(posedge clk);
			chk("login", login, i == 0);
		end
		bus(1'b1, `SCR_OFS_CTRL, 32'hD);
		@(posedge clk);
		chk("unlock", login, 32'h1);
		$display("pin done");
		conclude();
	end
endmodule
